/* File: gpio_link_device.sv */
`timescale 1ns/1ps
`include "gpio_link_params.svh"
module gpio_link_device
  import gpio_link_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // link side
  gpio_link_if.device           link,
  // pins
  input  wire gpio_link_pkg::pin_vec_t pin_in,
  output gpio_link_pkg::pin_vec_t      pin_out,
  output gpio_link_pkg::pin_vec_t      pin_oe,
  output gpio_link_pkg::pin_vec_t      pin_pulldown,
  // sensor comparator results for pins 0 and 1
  input  wire logic             volt_below,
  input  wire logic             volt_above
);
  import gpio_link_pkg::*;

  typedef struct packed {
    pin_vec_t sync1;
    pin_vec_t sync2;
    logic [1:0] vsync1;
    logic [1:0] vsync2;
    byte_t    dir;
    byte_t    local_data;
    byte_t    sensor_ctl;
    byte_t    limit;
    byte_t    alarm_en;
    byte_t    alarm_fwd;
    logic [2:0] fwd_count;
    logic [2:0] frame_cnt;
    byte_t    rdata;
    logic     rvalid;
    pin_vec_t fwd_pins;
    logic     fwd_valid;
    logic [1:0] alarm_bits;
    logic     alarm_valid;
    pin_vec_t out;
    pin_vec_t oe;
    pin_vec_t pd;
  } dev_s;

  dev_s       st_q, st_d;
  logic [2:0] div;
  byte_t      rd_word;
  pin_vec_t   link_mask;
  logic [1:0] alarm_now;
  logic       alarm_armed;
  logic       remote_sel;

  // frames between forward samples for a linked-pin count
  function automatic logic [2:0] frames_per_sample(input logic [2:0] count);
    logic [2:0] period;
    period = `SAMPLE_DIV_FIVE;
    if (count <= 3'h1) begin
      period = 3'h1;
    end else if (count == 3'h2) begin
      period = `SAMPLE_DIV_TWO;
    end
    return period;
  endfunction

  // pins at or above the linked count are sent as zero
  function automatic pin_vec_t linked_pins(input logic [2:0] count);
    pin_vec_t mask;
    mask = '0;
    for (int p = 0; p < 4; p++) begin
      if (p < int'(count)) begin
        mask[p] = 1'b1;
      end
    end
    return mask;
  endfunction

  // below/above flags in their own bit positions
  function automatic byte_t sensor_status(input logic [1:0] flags);
    byte_t word;
    word = 8'h00;
    word[`STS_BELOW_BIT] = flags[0];
    word[`STS_ABOVE_BIT] = flags[1];
    return word;
  endfunction

  // unmapped addresses answer zero
  function automatic byte_t read_word(input dev_s s, input byte_t addr);
    byte_t word;
    word = 8'h00;
    unique case (addr)
      `REG_PIN_DIR:       word = s.dir;
      `REG_LOCAL_DATA:    word = s.local_data;
      `REG_SENSOR_CTL:    word = s.sensor_ctl;
      `REG_SENSOR_LIMIT:  word = s.limit;
      `REG_ALARM_EN:      word = s.alarm_en;
      `REG_ALARM_FWD:     word = s.alarm_fwd;
      `REG_FWD_COUNT:     word = {5'h00, s.fwd_count};
      `REG_PIN_STATUS:    word = {4'h0, s.sync2 & s.dir[3:0]};
      `REG_SENSOR_STATUS: word = sensor_status(s.vsync2);
      default: ;
    endcase
    return word;
  endfunction

  // only flags both enabled and forwarded leave the device
  function automatic logic [1:0] alarm_word(input dev_s s);
    logic [1:0] word;
    word = s.vsync2 & s.alarm_en[1:0] & s.alarm_fwd[1:0];
    return word;
  endfunction

  // register writes; read-only and unmapped addresses drop the data
  function automatic dev_s apply_write(input dev_s s, input byte_t addr, input byte_t data);
    dev_s n;
    n = s;
    unique case (addr)
      `REG_PIN_DIR:      n.dir        = data;
      `REG_LOCAL_DATA:   n.local_data = data;
      `REG_SENSOR_CTL:   n.sensor_ctl = data;
      `REG_SENSOR_LIMIT: n.limit      = data;
      `REG_ALARM_EN:     n.alarm_en   = data;
      `REG_ALARM_FWD:    n.alarm_fwd  = data;
      `REG_FWD_COUNT:    n.fwd_count  = data[2:0];
      default: ;
    endcase
    return n;
  endfunction

  always_comb begin
    st_d        = st_q;
    div         = frames_per_sample(st_q.fwd_count);
    link_mask   = linked_pins(st_q.fwd_count);
    rd_word     = read_word(st_q, link.reg_addr);
    alarm_now   = alarm_word(st_q);
    alarm_armed = st_q.sensor_ctl[0] && (|st_q.alarm_en[1:0]) && (|st_q.alarm_fwd[1:0]);
    remote_sel  = st_q.local_data[0];
    st_d.sync1  = pin_in;
    st_d.sync2  = st_q.sync1;
    st_d.vsync1 = {volt_above, volt_below};
    st_d.vsync2 = st_q.vsync1;
    // strobes last one cycle
    st_d.rvalid      = 1'b0;
    st_d.fwd_valid   = 1'b0;
    st_d.alarm_valid = 1'b0;
    if (link.reg_wr) begin
      st_d = apply_write(st_d, link.reg_addr, link.reg_wdata);
    end
    // read data is registered: answer one cycle after the strobe
    if (link.reg_rd) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = rd_word;
    end
    // count frames, sample on the last of each period
    // a count left from an older setting is harmless: the compare is >=
    if (link.fwd_frame && st_q.fwd_count != 3'h0) begin
      if (st_q.frame_cnt + 3'h1 >= div) begin
        st_d.frame_cnt = 3'h0;
        st_d.fwd_valid = 1'b1;
        st_d.fwd_pins  = st_q.sync2 & link_mask;
      end else begin
        st_d.frame_cnt = st_q.frame_cnt + 3'h1;
      end
    end
    // sensor alarms ride each forward frame
    if (alarm_armed && link.fwd_frame) begin
      st_d.alarm_bits  = alarm_now;
      st_d.alarm_valid = 1'b1;
    end
    // per-pin pad control
    // pull-down stays on while driving; the board must tolerate it
    for (int p = 0; p < 4; p++) begin
      st_d.oe[p] = st_q.dir[4 + p];
      st_d.pd[p] = st_q.dir[p];
      if (remote_sel) begin
        st_d.out[p] = link.remote_pins[p];
      end else begin
        st_d.out[p] = st_q.local_data[4 + p];
      end
    end
    if (sys_rst) begin
      st_d       = '0;
      st_d.dir   = `PIN_DIR_RESET;
      st_d.limit = `SENSOR_LIMIT_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    st_q <= st_d;
  end

  assign link.reg_rdata   = st_q.rdata;
  assign link.reg_rvalid  = st_q.rvalid;
  assign link.fwd_pins    = st_q.fwd_pins;
  assign link.fwd_valid   = st_q.fwd_valid;
  assign link.alarm_bits  = st_q.alarm_bits;
  assign link.alarm_valid = st_q.alarm_valid;
  assign pin_out      = st_q.out;
  assign pin_oe       = st_q.oe;
  assign pin_pulldown = st_q.pd;
endmodule

/* File: gpio_link_params.svh */
`ifndef GPIO_LINK_PARAMS_SVH
`define GPIO_LINK_PARAMS_SVH
// Overview of operation
// - four pins, registers at nine addresses
// - level status register reports synchronised pins
// - output read-back needs both enables set
// - input enable connects internal pull-down
// - reset: all inputs, outputs disabled
// - direction bits 3:0 are input enables
// - direction bits 7:4 are output enables
// - input use requires output enable clear
// - software sets forwarded pin count field
// - up to four pins carried forward
// - sample every 1, 2 or 5 frames
// - forward latency about 225 ns
// - pin toggles at most quarter sample rate
// - pins 0 and 1 sense voltage
// - sensor status bits 2,3 below/above limits
// - enabled alarms sent over back channel
// - outputs driven from local data bits 7:4, or from remote pins when bit 0 set
`define REG_LOCAL_DATA      8'h0D
`define REG_PIN_DIR         8'h0E
`define REG_SENSOR_CTL      8'h17
`define REG_SENSOR_LIMIT    8'h1A
`define REG_ALARM_EN        8'h1D
`define REG_ALARM_FWD       8'h1E
`define REG_FWD_COUNT       8'h33
`define REG_PIN_STATUS      8'h53
`define REG_SENSOR_STATUS   8'h57
`define PIN_DIR_RESET       8'h0F
`define LOCAL_DATA_RESET    8'h00
`define SENSOR_LIMIT_RESET  8'h62
`define FWD_LATENCY_NS      225
`define CLK_PERIOD_NS       40
`define FWD_LATENCY_CYC     ((`FWD_LATENCY_NS) / (`CLK_PERIOD_NS))
`define SAMPLE_DIV_TWO      3'h2
`define SAMPLE_DIV_FIVE     3'h5
`define STS_BELOW_BIT       2
`define STS_ABOVE_BIT       3
`endif

/* File: gpio_link_pkg.sv */
package gpio_link_pkg;
  typedef logic [3:0] pin_vec_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_READ  = 2'b10
  } acc_e;
endpackage

/* File: gpio_link_if.sv */
`timescale 1ns/1ps
interface gpio_link_if;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic       fwd_frame;
  logic [3:0] fwd_pins;
  logic       fwd_valid;
  logic [3:0] remote_pins;
  logic [1:0] alarm_bits;
  logic       alarm_valid;
  modport device (
    input  reg_wr, reg_rd, reg_addr, reg_wdata, fwd_frame, remote_pins,
    output reg_rdata, reg_rvalid, fwd_pins, fwd_valid, alarm_bits, alarm_valid
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata, fwd_frame, remote_pins,
    input  reg_rdata, reg_rvalid, fwd_pins, fwd_valid, alarm_bits, alarm_valid
  );
endinterface

/* File: gpio_link_host.sv */
`timescale 1ns/1ps
`include "gpio_link_params.svh"
module gpio_link_host
  import gpio_link_pkg::*;
(
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   sys_rst,
  // link side
  gpio_link_if.host   link,
  // user command
  input  wire logic   cmd_wr,
  input  wire logic   cmd_rd,
  input  wire gpio_link_pkg::byte_t cmd_addr,
  input  wire gpio_link_pkg::byte_t cmd_wdata,
  input  wire logic   frame_tick,
  input  wire gpio_link_pkg::pin_vec_t remote_in,
  // user answers
  output gpio_link_pkg::byte_t   rsp_data,
  output logic                   rsp_valid,
  output gpio_link_pkg::pin_vec_t fwd_level,
  output logic [1:0]             alarm_level
);
  import gpio_link_pkg::*;

  typedef struct packed {
    acc_e     acc;
    byte_t    addr;
    byte_t    wdata;
    logic     frame;
    pin_vec_t remote;
    byte_t    rsp;
    logic     rsp_v;
    pin_vec_t fwd;
    logic [1:0] alarm;
  } host_s;

  host_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.acc   = ACC_IDLE;
    st_d.rsp_v = 1'b0;
    if (cmd_wr) begin
      st_d.acc   = ACC_WRITE;
      st_d.addr  = cmd_addr;
      st_d.wdata = cmd_wdata;
    end else if (cmd_rd) begin
      st_d.acc  = ACC_READ;
      st_d.addr = cmd_addr;
    end
    st_d.frame  = frame_tick;
    st_d.remote = remote_in;
    if (link.reg_rvalid) begin
      st_d.rsp   = link.reg_rdata;
      st_d.rsp_v = 1'b1;
    end
    if (link.fwd_valid)
      st_d.fwd = link.fwd_pins;
    if (link.alarm_valid)
      st_d.alarm = link.alarm_bits;
    if (sys_rst)
      st_d = '0;
  end

  always_ff @(posedge clk_sys) begin
    st_q <= st_d;
  end

  assign link.reg_wr      = (st_q.acc == ACC_WRITE);
  assign link.reg_rd      = (st_q.acc == ACC_READ);
  assign link.reg_addr    = st_q.addr;
  assign link.reg_wdata   = st_q.wdata;
  assign link.fwd_frame   = st_q.frame;
  assign link.remote_pins = st_q.remote;
  assign rsp_data    = st_q.rsp;
  assign rsp_valid   = st_q.rsp_v;
  assign fwd_level   = st_q.fwd;
  assign alarm_level = st_q.alarm;
endmodule

/* File: gpio_link_props.sv */
`timescale 1ns/1ps
module gpio_link_props (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // link signals
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       fwd_frame,
  input wire logic [3:0] fwd_pins,
  input wire logic       fwd_valid,
  input wire logic       alarm_valid
);
  typedef struct packed {
    logic [7:0] dir;
    logic [2:0] cnt;
  } shadow_s;
  shadow_s sh_q;
  shadow_s sh_d;
  // shadow of what the host wrote, to judge read-back and masking
  always_comb begin
    sh_d = sh_q;
    if (reg_wr && reg_addr == 8'h0E) sh_d.dir = reg_wdata;
    if (reg_wr && reg_addr == 8'h33) sh_d.cnt = reg_wdata[2:0];
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) sh_q <= '{dir: 8'h0F, cnt: 3'h0};
    else sh_q <= sh_d;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered in one cycle");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read data without a read");
  a_status_masked: assert property (reg_rvalid && $past(reg_addr) == 8'h53 |->
    (reg_rdata & ~{4'h0, sh_q.dir[3:0]}) == 8'h00) else $error("status shows a pin without input enable");
  a_dir_readback: assert property (reg_rvalid && $past(reg_addr) == 8'h0E |->
    reg_rdata == sh_q.dir) else $error("direction register read-back wrong");
  a_unmapped_zero: assert property (reg_rvalid && !($past(reg_addr) inside
    {8'h0D, 8'h0E, 8'h17, 8'h1A, 8'h1D, 8'h1E, 8'h33, 8'h53, 8'h57}) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_fwd_after_frame: assert property (fwd_valid |-> $past(fwd_frame))
    else $error("forward sample without a frame");
  a_single_every: assert property (fwd_frame && sh_q.cnt == 3'h1 |=> fwd_valid)
    else $error("single linked pin not sampled each frame");
  a_fwd_above_count: assert property (fwd_valid |-> sh_q.cnt != 3'h0 && (fwd_pins >> sh_q.cnt) == 4'h0)
    else $error("forwarded pin above count");
  a_alarm_after_frame: assert property (alarm_valid |-> $past(fwd_frame))
    else $error("alarm sent outside a frame");
  c_fwd: cover property (fwd_valid);
  c_alarm: cover property (alarm_valid);
  c_status: cover property (reg_rvalid && $past(reg_addr) == 8'h53);
endmodule

/* File: serializer_gpio_port_test.sv */
`timescale 1ns/1ps
module serializer_gpio_port_test;
  import gpio_link_pkg::*;
  logic       clk_sys, sys_rst, cmd_wr, cmd_rd, frame_tick, volt_below, volt_above, rsp_valid;
  byte_t      cmd_addr, cmd_wdata, rsp_data, d, v, lv;
  pin_vec_t   remote_in, fwd_level, pin_in, pin_out, pin_oe, pin_pulldown, ext;
  logic [1:0] alarm_level;
  int         mismatches, comparisons, fwd_n, seed, i;
  gpio_link_if link();
  gpio_link_device i_gpio_link_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pulldown(pin_pulldown), .volt_below(volt_below), .volt_above(volt_above));
  gpio_link_host i_gpio_link_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .frame_tick(frame_tick), .remote_in(remote_in), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .fwd_level(fwd_level), .alarm_level(alarm_level));
  gpio_link_props i_gpio_link_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid),
    .fwd_frame(link.fwd_frame), .fwd_pins(link.fwd_pins), .fwd_valid(link.fwd_valid), .alarm_valid(link.alarm_valid));
  // pad level: own driver where enabled, outside world elsewhere
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (link.fwd_valid === 1'b1) fwd_n++;
  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input byte_t a, input byte_t w);
    @(posedge clk_sys);
    cmd_addr <= a;
    cmd_wdata <= w;
    cmd_wr <= 1'b1;
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
  endtask
  task automatic rd(input byte_t a, output byte_t r);
    int k;
    @(posedge clk_sys);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge clk_sys);
    cmd_rd <= 1'b0;
    for (k = 0; k < 20 && rsp_valid !== 1'b1; k++) @(posedge clk_sys) #1;
    if (k == 20) begin
      mismatches++;
      finish_test();
    end
    r = rsp_data;
  endtask
  task automatic frames(input int n);
    @(posedge clk_sys) #1;
    fwd_n = 0;
    repeat (n) begin
      @(posedge clk_sys) frame_tick <= 1'b1;
      @(posedge clk_sys) frame_tick <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask
  function automatic int exp_samples(input int c, input int n);
    return c == 1 ? n : c == 2 ? n / 2 : c == 0 ? 0 : n / 5;
  endfunction
  function automatic pin_vec_t count_mask(input int c);
    return c >= 4 ? 4'hF : pin_vec_t'((4'h1 << c) - 4'h1);
  endfunction
  initial begin
    repeat (50000) @(posedge clk_sys);
    mismatches++;
    finish_test();
  end
  initial begin
    seed = 32'h4354d5f0;
    {cmd_wr, cmd_rd, frame_tick, volt_below, volt_above} = 5'h00;
    {cmd_addr, cmd_wdata, remote_in, ext} = '0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys) #1;
    chk("oe after reset", {4'h0, pin_oe}, 8'h00);
    chk("pulldown after reset", {4'h0, pin_pulldown}, 8'h0F);
    rd(8'h0E, v);
    chk("dir reset", v, 8'h0F);
    for (i = 0; i < 8; i++) begin
      d = i == 0 ? 8'hFF : i == 1 ? 8'hF0 : byte_t'($random(seed));
      lv = byte_t'($random(seed)) & 8'hF0;
      @(posedge clk_sys) ext <= pin_vec_t'($random(seed));
      wr(8'h0D, lv);
      wr(8'h0E, d);
      rd(8'h0E, v);
      chk("dir read-back", v, d);
      chk("oe", {4'h0, pin_oe}, {4'h0, d[7:4]});
      chk("pulldown", {4'h0, pin_pulldown}, {4'h0, d[3:0]});
      chk("local drive", {4'h0, pin_out & pin_oe}, {4'h0, lv[7:4] & d[7:4]});
      rd(8'h53, v);
      chk("pin status", v, {4'h0, ((d[7:4] & lv[7:4]) | (~d[7:4] & ext)) & d[3:0]});
    end
    rd(8'h99, v);
    chk("unmapped", v, 8'h00);
    wr(8'h0E, 8'hF0);
    wr(8'h0D, 8'h01);
    @(posedge clk_sys) remote_in <= pin_vec_t'($random(seed)) | 4'h1;
    // one flop in the host, one in the device
    repeat (2) @(posedge clk_sys) #1;
    chk("remote drive", {4'h0, pin_out}, {4'h0, remote_in});
    wr(8'h0E, 8'h0F);
    for (i = 0; i < 5; i++) begin
      wr(8'h33, byte_t'((i + 1) % 5));
      // pins held still across many frames
      @(posedge clk_sys) ext <= pin_vec_t'($random(seed));
      frames(10);
      chk("samples", fwd_n[7:0], 8'(exp_samples((i + 1) % 5, 10)));
      if (i < 4) chk("fwd level", {4'h0, fwd_level}, {4'h0, ext & count_mask(i + 1)});
    end
    wr(8'h17, 8'h01);
    wr(8'h1D, 8'h03);
    wr(8'h1E, 8'h03);
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys) {volt_above, volt_below} <= 2'(i);
      frames(2);
      rd(8'h57, v);
      chk("sensor status", {6'h00, v[3:2]}, 8'(i));
      chk("alarm level", {6'h00, alarm_level}, 8'(i));
    end
    finish_test();
  end
endmodule
